//--- src/dac_switch_ctrl.sv
// Switch-mode sample presentation, clock trim and serial register file of the converter
module dac_switch_ctrl (
	input  wire logic                         clk_i,
	input  wire logic                         reset_i,
	input  wire logic [15:0]                  sample_i,
	input  wire logic                         spi_cs_n_i,
	input  wire logic                         spi_sclk_i,
	input  wire logic                         spi_mosi_i,
	output dac_ctrl_pkg::core_drive_type      core_o,
	output dac_ctrl_pkg::clk_trim_type        trim_o,
	output logic                              spi_miso_o
);
	// Address decode shared by write path, read path and checks
	function automatic dac_ctrl_pkg::reg_sel_type reg_sel(input logic [14:0] a);
		if (a == dac_ctrl_pkg::ADDR_SKEW) reg_sel = dac_ctrl_pkg::SEL_SKEW;
		else if (a == dac_ctrl_pkg::ADDR_DUTY) reg_sel = dac_ctrl_pkg::SEL_DUTY;
		else if (a == dac_ctrl_pkg::ADDR_CLK_AUX0) reg_sel = dac_ctrl_pkg::SEL_AUX0;
		else if (a == dac_ctrl_pkg::ADDR_CLK_AUX1) reg_sel = dac_ctrl_pkg::SEL_AUX1;
		else if (a >= dac_ctrl_pkg::ADDR_DLL_FIRST && a <= dac_ctrl_pkg::ADDR_DLL_LAST)
			reg_sel = dac_ctrl_pkg::SEL_DLL;
		else if (a == dac_ctrl_pkg::ADDR_SHUFFLE) reg_sel = dac_ctrl_pkg::SEL_SHUF;
		else if (a == dac_ctrl_pkg::ADDR_MODE) reg_sel = dac_ctrl_pkg::SEL_MODE;
		else reg_sel = dac_ctrl_pkg::SEL_NONE;
	endfunction

	// Thermometer code of the MSB nibble, rotated right by amt (15 counts as 0)
	function automatic logic [14:0] seg_code(input logic [3:0] m, input logic [3:0] amt);
		logic [14:0] t;
		logic [29:0] d;
		logic [3:0]  r;
		t = '0;
		for (int i = 0; i < 15; i++) begin
			t[i] = (i < int'(m));
		end
		r = (amt == 4'hf) ? 4'h0 : amt;
		d = {t, t} >> r;
		seg_code = d[14:0];
	endfunction

	logic                        cs_meta, cs_sync, sclk_meta, sclk_sync, sclk_prev;
	logic                        mosi_meta, mosi_sync;
	dac_ctrl_pkg::spi_state_type spi_state, next_spi_state;
	logic [4:0]                  bit_cnt, next_bit_cnt;
	logic [15:0]                 shift, next_shift;
	logic [14:0]                 addr, next_addr;
	logic                        read_op, next_read;
	logic [1:0]                  load, next_load;
	logic [7:0]                  rd_shift, next_rd_shift, rd_val, dll_rd;
	logic                        miso, next_miso;
	logic                        sclk_rise, sclk_fall, wr_stb;
	logic [7:0]                  wr_data;
	dac_ctrl_pkg::reg_sel_type   sel;
	logic [7:0]                  skew, duty, aux0, aux1, shuf, mode;
	logic [7:0]                  next_skew, next_duty, next_aux0, next_aux1, next_shuf;
	logic [7:0]                  next_mode;
	dac_ctrl_pkg::clk_trim_type  trim, next_trim;
	logic [15:0]                 cur, fall_val, avg;
	logic [16:0]                 sum;
	logic [7:0]                  lfsr, next_lfsr;
	dac_ctrl_pkg::core_drive_type core, next_core;
	dac_ctrl_pkg::out_mode_type  out_mode;
	logic                        filt_en, shuf_en;

	// Two-flop synchronisers for the serial pins
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cs_meta   <= 1'b1;
			cs_sync   <= 1'b1;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_prev <= 1'b0;
			mosi_meta <= 1'b0;
			mosi_sync <= 1'b0;
		end else begin
			cs_meta   <= spi_cs_n_i;
			cs_sync   <= cs_meta;
			sclk_meta <= spi_sclk_i;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
			mosi_meta <= spi_mosi_i;
			mosi_sync <= mosi_meta;
		end
	end

	assign sclk_rise = sclk_sync & ~sclk_prev;
	assign sclk_fall = ~sclk_sync & sclk_prev;
	assign wr_data   = {shift[6:0], mosi_sync};
	assign wr_stb    = !cs_sync && spi_state == dac_ctrl_pkg::SPI_DATA && sclk_rise
		&& bit_cnt == dac_ctrl_pkg::SPI_FRAME_LAST && !read_op;
	assign sel       = reg_sel(addr);

	// Serial frame engine: instruction, then one data byte
	always_comb begin
		next_spi_state = spi_state;
		next_bit_cnt   = bit_cnt;
		next_shift     = shift;
		next_addr      = addr;
		next_read      = read_op;
		next_load      = {load[0], 1'b0};
		next_rd_shift  = rd_shift;
		next_miso      = miso;
		if (load[1]) next_rd_shift = rd_val;
		if (cs_sync) begin
			next_spi_state = dac_ctrl_pkg::SPI_IDLE;
			next_bit_cnt   = 5'h00;
			next_miso      = 1'b0;
		end else begin
			case (spi_state)
				dac_ctrl_pkg::SPI_IDLE: begin
					next_spi_state = dac_ctrl_pkg::SPI_INSTR;
					next_bit_cnt   = 5'h00;
				end
				dac_ctrl_pkg::SPI_INSTR: if (sclk_rise) begin
					next_shift   = {shift[14:0], mosi_sync};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == dac_ctrl_pkg::SPI_INSTR_LAST) begin
						next_spi_state = dac_ctrl_pkg::SPI_DATA;
						next_read      = shift[14];
						next_addr      = {shift[13:0], mosi_sync};
						next_load[0]   = 1'b1;
					end
				end
				dac_ctrl_pkg::SPI_DATA: begin
					if (sclk_rise) begin
						next_shift   = {shift[14:0], mosi_sync};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == dac_ctrl_pkg::SPI_FRAME_LAST)
							next_spi_state = dac_ctrl_pkg::SPI_DONE;
					end
					if (sclk_fall) begin
						next_miso     = rd_shift[7];
						next_rd_shift = {rd_shift[6:0], 1'b0};
					end
				end
				default: next_spi_state = spi_state;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			spi_state <= dac_ctrl_pkg::SPI_IDLE;
			bit_cnt   <= 5'h00;
			shift     <= 16'h0000;
			addr      <= 15'h0000;
			read_op   <= 1'b0;
			load      <= 2'h0;
			rd_shift  <= 8'h00;
			miso      <= 1'b0;
		end else begin
			spi_state <= next_spi_state;
			bit_cnt   <= next_bit_cnt;
			shift     <= next_shift;
			addr      <= next_addr;
			read_op   <= next_read;
			load      <= next_load;
			rd_shift  <= next_rd_shift;
			miso      <= next_miso;
		end
	end

	// DLL configuration words, low address nibble is the index
	dll_cfg_mem u_dll_cfg_mem (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.wr_en_i   (wr_stb && sel == dac_ctrl_pkg::SEL_DLL),
		.addr_i    (addr[3:0]),
		.wr_data_i (wr_data),
		.rd_data_o (dll_rd)
	);

	// Register writes and read-back selection; unmapped reads return zero
	always_comb begin
		next_skew = skew;
		next_duty = duty;
		next_aux0 = aux0;
		next_aux1 = aux1;
		next_shuf = shuf;
		next_mode = mode;
		if (wr_stb) begin
			if (sel == dac_ctrl_pkg::SEL_SKEW) next_skew = wr_data;
			else if (sel == dac_ctrl_pkg::SEL_DUTY) next_duty = wr_data;
			else if (sel == dac_ctrl_pkg::SEL_AUX0) next_aux0 = wr_data;
			else if (sel == dac_ctrl_pkg::SEL_AUX1) next_aux1 = wr_data;
			else if (sel == dac_ctrl_pkg::SEL_SHUF) next_shuf = wr_data;
			else if (sel == dac_ctrl_pkg::SEL_MODE) next_mode = wr_data;
		end
		if (sel == dac_ctrl_pkg::SEL_SKEW) rd_val = skew;
		else if (sel == dac_ctrl_pkg::SEL_DUTY) rd_val = duty;
		else if (sel == dac_ctrl_pkg::SEL_AUX0) rd_val = aux0;
		else if (sel == dac_ctrl_pkg::SEL_AUX1) rd_val = aux1;
		else if (sel == dac_ctrl_pkg::SEL_DLL) rd_val = dll_rd;
		else if (sel == dac_ctrl_pkg::SEL_SHUF) rd_val = shuf;
		else if (sel == dac_ctrl_pkg::SEL_MODE) rd_val = mode;
		else rd_val = 8'h00;
	end

	// Clock trim controls decoded from the duty and phase registers
	always_comb begin
		next_trim.duty_corr_en = duty[dac_ctrl_pkg::DUTY_CORR_BIT];
		next_trim.duty_ofs_en  = duty[dac_ctrl_pkg::DUTY_OFS_EN_BIT];
		next_trim.duty_ofs_neg = duty[dac_ctrl_pkg::DUTY_SIGN_BIT];
		next_trim.duty_ofs_mag = duty[3:0];
		next_trim.clkp_steps   = skew[dac_ctrl_pkg::SKEW_SIGN_BIT] ? 5'h00 : skew[4:0];
		next_trim.clkn_steps   = skew[dac_ctrl_pkg::SKEW_SIGN_BIT] ? skew[4:0] : 5'h00;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			skew <= dac_ctrl_pkg::REG_RESET;
			duty <= dac_ctrl_pkg::REG_RESET;
			aux0 <= dac_ctrl_pkg::REG_RESET;
			aux1 <= dac_ctrl_pkg::REG_RESET;
			shuf <= dac_ctrl_pkg::REG_RESET;
			mode <= dac_ctrl_pkg::REG_RESET;
			trim <= '0;
		end else begin
			skew <= next_skew;
			duty <= next_duty;
			aux0 <= next_aux0;
			aux1 <= next_aux1;
			shuf <= next_shuf;
			mode <= next_mode;
			trim <= next_trim;
		end
	end

	assign out_mode = dac_ctrl_pkg::out_mode_type'(mode[1:0]);
	assign filt_en  = mode[dac_ctrl_pkg::FILTER_EN_BIT];
	assign shuf_en  = shuf[dac_ctrl_pkg::SHUFFLE_EN_BIT];
	assign sum      = {1'b0, cur} + {1'b0, sample_i};
	assign avg      = sum[16:1];

	// Half-period words: rising word to pair A, falling word to pair B
	always_comb begin
		next_lfsr = lfsr;
		if (shuf_en) next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		if (filt_en) fall_val = avg;
		else begin
			case (out_mode)
				dac_ctrl_pkg::MODE_RZ:   fall_val = dac_ctrl_pkg::RZ_ZERO_CODE;
				dac_ctrl_pkg::MODE_CHOP: fall_val = ~cur;
				default:                 fall_val = cur;
			endcase
		end
		next_core.pair_rise = dac_ctrl_pkg::PAIR_A;
		next_core.pair_fall = dac_ctrl_pkg::PAIR_B;
		next_core.rise.seg  = seg_code(cur[15:12], shuf_en ? lfsr[3:0] : 4'h0);
		next_core.rise.lsb  = cur[11:0];
		next_core.fall.seg  = seg_code(fall_val[15:12], shuf_en ? lfsr[7:4] : 4'h0);
		next_core.fall.lsb  = fall_val[11:0];
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cur  <= 16'h0000;
			lfsr <= dac_ctrl_pkg::LFSR_SEED;
			core <= '0;
		end else begin
			cur  <= sample_i;
			lfsr <= next_lfsr;
			core <= next_core;
		end
	end

	assign core_o     = core;
	assign trim_o     = trim;
	assign spi_miso_o = miso;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	property p_pairs;
		!$past(reset_i) |-> core.pair_rise == 2'h1 && core.pair_fall == 2'h2;
	endproperty
	a_pairs: assert property (p_pairs) else $error("switch pairs not alternating");
	property p_rz;
		(out_mode == dac_ctrl_pkg::MODE_RZ && !filt_en) |=> core.fall == '0
			&& core.rise.lsb == $past(cur[11:0]);
	endproperty
	a_rz: assert property (p_rz) else $error("falling half not zero in RZ");
	property p_chop;
		(out_mode == dac_ctrl_pkg::MODE_CHOP && !filt_en) |=> core.fall.lsb == ~core.rise.lsb
			&& $countones(core.fall.seg) + $countones(core.rise.seg) == 15;
	endproperty
	a_chop: assert property (p_chop) else $error("falling half not complement");
	property p_nrz;
		(out_mode inside {dac_ctrl_pkg::MODE_NRZ, dac_ctrl_pkg::MODE_RSVD} && !filt_en)
			|=> core.fall.lsb == core.rise.lsb
			&& $countones(core.fall.seg) == $countones(core.rise.seg);
	endproperty
	a_nrz: assert property (p_nrz) else $error("halves differ in NRZ");
	property p_mode_wr;
		(wr_stb && sel == dac_ctrl_pkg::SEL_MODE) |=> mode == $past(wr_data);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
	property p_filt;
		filt_en |=> core.fall.lsb == $past(avg[11:0]) && core.rise.lsb == $past(cur[11:0]);
	endproperty
	a_filt: assert property (p_filt) else $error("filter midpoint wrong");
	property p_duty;
		(wr_stb && sel == dac_ctrl_pkg::SEL_DUTY) |-> ##2 trim.duty_corr_en == $past(wr_data[7], 2)
			&& trim.duty_ofs_en == $past(wr_data[6], 2)
			&& trim.duty_ofs_neg == $past(wr_data[4], 2) && trim.duty_ofs_mag == $past(wr_data[3:0], 2);
	endproperty
	a_duty: assert property (p_duty) else $error("duty trim decode wrong");
	property p_skew;
		(wr_stb && sel == dac_ctrl_pkg::SEL_SKEW) |-> ##2
			(trim.clkp_steps == ($past(wr_data[5], 2) ? 5'h00 : $past(wr_data[4:0], 2)))
			&& (trim.clkn_steps == ($past(wr_data[5], 2) ? $past(wr_data[4:0], 2) : 5'h00));
	endproperty
	a_skew: assert property (p_skew) else $error("phase trim decode wrong");
	// Unshuffled rising-half segments must be packed from bit 0 upward, independent of the encoder
	property p_noshuf;
		!shuf_en |=> (core.rise.seg & (core.rise.seg + 15'h0001)) == 15'h0000;
	endproperty
	a_noshuf: assert property (p_noshuf) else $error("segments moved without shuffle");
	property p_msb_only;
		1'b1 |=> core.rise.lsb == $past(cur[11:0])
			&& $countones(core.rise.seg) == $past(cur[15:12]);
	endproperty
	a_msb_only: assert property (p_msb_only) else $error("shuffle touched LSBs");
	property p_cnt;
		bit_cnt <= 5'h18;
	endproperty
	a_cnt: assert property (p_cnt) else $error("frame bit count overran");

	c_chop: cover property (out_mode == dac_ctrl_pkg::MODE_CHOP && !filt_en);
	c_rz: cover property (out_mode == dac_ctrl_pkg::MODE_RZ && !filt_en);
	c_shuf: cover property (shuf_en && (core.rise.seg & (core.rise.seg + 15'h0001)) != 15'h0000);
	c_dll_wr: cover property (wr_stb && sel == dac_ctrl_pkg::SEL_DLL);
endmodule

//--- src/dac_ctrl_pkg.sv
// Shared constants, register map and types of the converter switch-mode control block
package dac_ctrl_pkg;

	// Sample and segment layout
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned MSB_W    = 4;
	localparam int unsigned LSB_W    = 12;
	localparam int unsigned SEG_W    = 15;

	// Serial register map (15-bit addresses)
	localparam logic [14:0] ADDR_SKEW      = 15'h007f;
	localparam logic [14:0] ADDR_DUTY      = 15'h0082;
	localparam logic [14:0] ADDR_CLK_AUX0  = 15'h0083;
	localparam logic [14:0] ADDR_CLK_AUX1  = 15'h0084;
	localparam logic [14:0] ADDR_DLL_FIRST = 15'h0090;
	localparam logic [14:0] ADDR_DLL_LAST  = 15'h009b;
	localparam logic [14:0] ADDR_SHUFFLE   = 15'h0151;
	localparam logic [14:0] ADDR_MODE      = 15'h0152;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam int unsigned DLL_DEPTH      = 12;

	// Field positions
	localparam int unsigned DUTY_CORR_BIT   = 7;
	localparam int unsigned DUTY_OFS_EN_BIT = 6;
	localparam int unsigned DUTY_SIGN_BIT   = 4;
	localparam int unsigned SKEW_SIGN_BIT   = 5;
	localparam int unsigned SHUFFLE_EN_BIT  = 2;
	localparam int unsigned FILTER_EN_BIT   = 2;

	// Serial frame: read flag, 15 address bits, 8 data bits
	localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
	localparam logic [4:0] SPI_FRAME_LAST = 5'h17;

	// Datapath constants
	localparam logic [15:0] RZ_ZERO_CODE = 16'h0000;
	localparam logic [7:0]  LFSR_SEED    = 8'h5b;
	localparam logic [1:0]  PAIR_A       = 2'h1;
	localparam logic [1:0]  PAIR_B       = 2'h2;

	typedef enum logic [1:0] {
		MODE_NRZ  = 2'h0,
		MODE_CHOP = 2'h1,
		MODE_RZ   = 2'h2,
		MODE_RSVD = 2'h3
	} out_mode_type;

	typedef enum logic [1:0] {
		SPI_IDLE  = 2'h0,
		SPI_INSTR = 2'h1,
		SPI_DATA  = 2'h3,
		SPI_DONE  = 2'h2
	} spi_state_type;

	typedef enum logic [2:0] {
		SEL_NONE, SEL_SKEW, SEL_DUTY, SEL_AUX0, SEL_AUX1, SEL_DLL, SEL_SHUF, SEL_MODE
	} reg_sel_type;

	typedef struct packed {
		logic [14:0] seg;
		logic [11:0] lsb;
	} half_word_type;

	typedef struct packed {
		logic [1:0]    pair_rise;
		logic [1:0]    pair_fall;
		half_word_type rise;
		half_word_type fall;
	} core_drive_type;

	typedef struct packed {
		logic       duty_corr_en;
		logic       duty_ofs_en;
		logic       duty_ofs_neg;
		logic [3:0] duty_ofs_mag;
		logic [4:0] clkp_steps;
		logic [4:0] clkn_steps;
	} clk_trim_type;

endpackage

//--- src/dll_cfg_mem.sv
// Twelve-word store for the delay-locked-loop configuration, registered read
module dll_cfg_mem (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       wr_en_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	output logic      [7:0] rd_data_o
);
	logic [7:0] mem [dac_ctrl_pkg::DLL_DEPTH];

	// Write port with reset, read data from a flop
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < dac_ctrl_pkg::DLL_DEPTH; i++) begin
				mem[i] <= dac_ctrl_pkg::REG_RESET;
			end
			rd_data_o <= dac_ctrl_pkg::REG_RESET;
		end else begin
			if (wr_en_i && (int'(addr_i) < dac_ctrl_pkg::DLL_DEPTH)) begin
				mem[addr_i] <= wr_data_i;
			end
			rd_data_o <= (int'(addr_i) < dac_ctrl_pkg::DLL_DEPTH) ? mem[addr_i] : 8'h00;
		end
	end
endmodule

//--- tb/dac_core_model.sv
// Behavioural model of the quad-switch core that decodes the words driven into it
module dac_core_model (
	input  wire dac_ctrl_pkg::core_drive_type drive_i,
	output logic [15:0]                       rise_val_o,
	output logic [15:0]                       fall_val_o,
	output logic                              pair_ok_o,
	output logic                              shuffled_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Count of lit segments gives back the upper nibble, whatever the order
	function automatic logic [3:0] ones(input logic [14:0] s);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 15; i++) begin
			n = n + {3'h0, s[i]};
		end
		return n;
	endfunction

	// Exactly one pair per half period, the two pairs on alternate edges
	assign pair_ok_o = (drive_i.pair_rise == dac_ctrl_pkg::PAIR_A)
		&& (drive_i.pair_fall == dac_ctrl_pkg::PAIR_B);
	// Rebuild the two half-period samples from segments and low bits
	assign rise_val_o = {ones(drive_i.rise.seg), drive_i.rise.lsb};
	assign fall_val_o = {ones(drive_i.fall.seg), drive_i.fall.lsb};
	// Segments not packed from bit 0 upward mean the shuffler moved them
	assign shuffled_o = ((drive_i.rise.seg & (drive_i.rise.seg + 15'h0001))
		!= 15'h0000);
endmodule

//--- tb/dac_switch_mode_and_clock_trim_bench.sv
// Self-checking bench of the switch-mode, clock trim and register control block
module dac_switch_mode_and_clock_trim_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                         clk = 1'b0;
	logic                         reset;
	logic [15:0]                  sample;
	logic                         cs_n;
	logic                         sclk;
	logic                         mosi;
	dac_ctrl_pkg::core_drive_type core;
	dac_ctrl_pkg::clk_trim_type   trim;
	logic                         miso;
	logic [15:0]                  rise_val;
	logic [15:0]                  fall_val;
	logic                         pair_ok;
	logic                         shuffled;
	logic [15:0]                  rnd = 16'h4e07;
	logic [7:0]                   d;
	int                           err_total = 0;
	int                           n_checks = 0;
	int                           cycles = 0;
	int                           s;
	logic [14:0] regs [9] = '{dac_ctrl_pkg::ADDR_SKEW, dac_ctrl_pkg::ADDR_DUTY,
		dac_ctrl_pkg::ADDR_CLK_AUX0, dac_ctrl_pkg::ADDR_CLK_AUX1, dac_ctrl_pkg::ADDR_DLL_FIRST,
		15'h0095, dac_ctrl_pkg::ADDR_DLL_LAST, dac_ctrl_pkg::ADDR_SHUFFLE, dac_ctrl_pkg::ADDR_MODE};
	logic [7:0]  duty_tab [5] = '{8'hd5, 8'h4f, 8'h80, 8'h00, 8'h3a};
	logic [7:0]  skew_tab [6] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h01, 8'h21};

	// Design and core model
	dac_switch_ctrl u_dac_switch_ctrl (.clk_i(clk), .reset_i(reset), .sample_i(sample),
		.spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .core_o(core),
		.trim_o(trim), .spi_miso_o(miso));
	dac_core_model u_dac_core_model (.drive_i(core), .rise_val_o(rise_val),
		.fall_val_o(fall_val), .pair_ok_o(pair_ok), .shuffled_o(shuffled));

	// Converter clock, 5 ns period
	always #2.5 clk = ~clk;

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// Wait n edges, then step just past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// One serial frame: direction flag, address, data, MSB first on clock rise
	task automatic spi(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
		output logic [7:0] rdata);
		logic [23:0] fr;
		fr = {rd, addr, wd};
		rdata = 8'h00;
		cs_n = 1'b0;
		cyc(6);
		for (int i = 23; i >= 0; i--) begin
			mosi = fr[i];
			cyc(6);
			if (i < 8) rdata[i] = miso;
			sclk = 1'b1;
			cyc(6);
			sclk = 1'b0;
		end
		cyc(6);
		cs_n = 1'b1;
		mosi = ~mosi;
		cyc(8);
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] v);
		logic [7:0] x;
		spi(1'b0, a, v, x);
	endtask

	task automatic rd_chk(input logic [14:0] a, input logic [7:0] e, input string msg);
		logic [7:0] x;
		spi(1'b1, a, 8'h00, x);
		check(x === e, msg);
	endtask

	// Falling-half word expected for a mode register value
	function automatic logic [15:0] exp_fall(input logic [7:0] m, input logic [15:0] a,
		input logic [15:0] b);
		logic [16:0] t;
		t = {1'b0, a} + {1'b0, b};
		if (m[dac_ctrl_pkg::FILTER_EN_BIT]) return t[16:1];
		case (m[1:0])
			2'h1: return ~a;
			2'h2: return dac_ctrl_pkg::RZ_ZERO_CODE;
			default: return a;
		endcase
	endfunction

	// Back-to-back samples, each checked two edges after it is driven
	task automatic stream(input logic [7:0] m, input int n, output int shuf);
		logic [15:0] h [$];
		shuf = 0;
		h = {sample, sample};
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			sample = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : rnd;
			h.push_back(sample);
			cyc(1);
			check(pair_ok === 1'b1, "switch pair codes");
			check(rise_val === h[1], "rising half word");
			check(fall_val === exp_fall(m, h[1], h[2]), "falling half word");
			if (shuffled === 1'b1) shuf++;
			void'(h.pop_front());
		end
	endtask

	initial begin
		reset = 1'b1;
		sample = 16'h1234;
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		cyc(4);
		// Reset values, then write and read back each register and the first, one middle and the last DLL word
		foreach (regs[i]) rd_chk(regs[i], dac_ctrl_pkg::REG_RESET, "reset value");
		foreach (regs[i]) begin
			rnd = lfsr(rnd);
			wr(regs[i], rnd[7:0]);
			rd_chk(regs[i], rnd[7:0], "register readback");
		end
		// Places just outside the clock range are not storage
		wr(15'h0085, 8'ha5);
		rd_chk(15'h0085, 8'h00, "unmapped read");
		wr(15'h0081, 8'h5a);
		rd_chk(15'h0081, 8'h00, "unmapped read");
		// Duty correction fields
		foreach (duty_tab[i]) begin
			d = duty_tab[i];
			wr(dac_ctrl_pkg::ADDR_DUTY, d);
			cyc(4);
			check(trim.duty_corr_en === d[7] && trim.duty_ofs_en === d[6], "duty enables");
			check(trim.duty_ofs_neg === d[4] && trim.duty_ofs_mag === d[3:0], "duty offset");
		end
		// Clock input skew steps, sign chooses the side
		foreach (skew_tab[i]) begin
			d = skew_tab[i];
			wr(dac_ctrl_pkg::ADDR_SKEW, d);
			cyc(4);
			check(trim.clkp_steps === (d[5] ? 5'h00 : d[4:0]), "positive side steps");
			check(trim.clkn_steps === (d[5] ? d[4:0] : 5'h00), "negative side steps");
		end
		// Every mode code, reserved code and filter on, shuffle held off
		wr(dac_ctrl_pkg::ADDR_SHUFFLE, 8'hfb);
		for (int m = 0; m < 6; m++) begin
			wr(dac_ctrl_pkg::ADDR_MODE, m[7:0]);
			cyc(6);
			stream(m[7:0], 24, s);
			check(s == 0, "segments moved with shuffle off");
		end
		// Shuffle on: segments move, values and low bits intact
		wr(dac_ctrl_pkg::ADDR_MODE, 8'h00);
		wr(dac_ctrl_pkg::ADDR_SHUFFLE, 8'h04);
		cyc(6);
		stream(8'h00, 40, s);
		check(s > 0, "segments never moved with shuffle on");
		finish_test();
	end
endmodule
